// ### ssf_pkg.sv
// ==========================================================
// Shared constants of the serial status block.
package ssf_pkg;
	// Register byte offsets on the bus.
	localparam logic [7:0] SSF_STATUS_OFS = 8'h00;
	localparam logic [7:0] SSF_CONTROL_OFS = 8'h04;
	localparam logic [7:0] SSF_RXBUF_OFS = 8'h08;
	localparam logic [7:0] SSF_TXBUF_OFS = 8'h0C;
	// Status field positions.
	localparam int SSF_TX_EMPTY_BIT = 7;
	localparam int SSF_RX_FULL_BIT = 6;
	localparam int SSF_OVERRUN_BIT = 5;
	localparam int SSF_FRAMING_BIT = 4;
	localparam int SSF_PARITY_BIT = 3;
	localparam int SSF_TX_END_BIT = 2;
	localparam int SSF_MP_BIT = 1;
	// Control field positions.
	localparam int SSF_CTL_TX_EN = 0;
	localparam int SSF_CTL_RX_EN = 1;
	localparam int SSF_CTL_SYNC = 2;
	localparam int SSF_CTL_PAR_EN = 3;
	localparam int SSF_CTL_ODD = 4;
	localparam int SSF_CTL_TWO_STOP = 5;
	localparam int SSF_CTL_MP_FMT = 6;
	// Reset values.
	localparam logic [7:0] SSF_STATUS_RESET = 8'h84;
	localparam logic [6:0] SSF_CONTROL_RESET = 7'h00;
	localparam logic [7:0] SSF_TXBUF_RESET = 8'hFF;
	// Odd count of ones across a data byte and its parity bit.
	function automatic logic ssf_odd_ones(input logic [7:0] data, input logic par);
		ssf_odd_ones = ^{data, par};
	endfunction
endpackage

// ### ssf_rx_check.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Receive character checker: flags framing and parity faults.
module ssf_rx_check
	import ssf_pkg::*;
(
	// Received character.
	input wire logic [7:0] data,
	input wire logic parity_bit,
	input wire logic first_stop_bit,
	// Format.
	input wire logic sync_mode,
	input wire logic parity_enable,
	input wire logic odd_parity,
	// Verdict.
	output logic framing_err,
	output logic parity_err
);
	// The second stop bit never reaches this check.
	assign framing_err = ~sync_mode & ~first_stop_bit;
	// Even parity wants an even count of ones, odd wants odd.
	assign parity_err = ~sync_mode & parity_enable & (ssf_odd_ones(data, parity_bit) != odd_parity);
endmodule
`default_nettype wire

// ### ssf_status.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Status flags of one serial channel, with APB register access.
module ssf_status
	import ssf_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Chip standby level.
	input wire logic standby,
	// Transmit engine events.
	input wire logic tx_load,
	input wire logic tx_last_bit,
	// Receive engine events.
	input wire logic rx_done,
	input wire logic [7:0] rx_shifter,
	input wire logic rx_parity_in,
	input wire logic rx_stop_in,
	input wire logic rx_mp_in,
	// DMA controller.
	input wire logic dma_tx_write,
	input wire logic [7:0] dma_tx_data,
	input wire logic dma_rx_read,
	// Towards the engines.
	output logic [7:0] tx_buffer,
	output logic [7:0] rx_buffer,
	output logic [7:0] serial_status,
	output logic [6:0] serial_control,
	output logic rx_halt,
	output logic tx_halt
);
	// ==========================================================
	// Bus decode.
	wire logic access = psel & penable;
	wire logic done = access & pready;
	wire logic wr_done = done & pwrite;
	wire logic hit_status = paddr == SSF_STATUS_OFS;
	wire logic hit_control = paddr == SSF_CONTROL_OFS;
	wire logic hit_rxbuf = paddr == SSF_RXBUF_OFS;
	wire logic hit_txbuf = paddr == SSF_TXBUF_OFS;
	wire logic mapped = hit_status | hit_control | hit_rxbuf | hit_txbuf;
	wire logic wr_status = wr_done & hit_status;
	wire logic rd_status = done & ~pwrite & hit_status;
	// Read data selected from the addressed register.
	wire logic [31:0] read_word = hit_status ? {24'h000000, serial_status} :
		hit_control ? {25'h0000000, serial_control} :
		hit_rxbuf ? {24'h000000, rx_buffer} :
		hit_txbuf ? {24'h000000, tx_buffer} : 32'h00000000;

	// ==========================================================
	// Control decode.
	wire logic tx_en = serial_control[SSF_CTL_TX_EN];
	wire logic rx_en = serial_control[SSF_CTL_RX_EN];
	wire logic sync_mode = serial_control[SSF_CTL_SYNC];
	wire logic mp_fmt = serial_control[SSF_CTL_MP_FMT];
	wire logic err_any = serial_status[SSF_OVERRUN_BIT] | serial_status[SSF_FRAMING_BIT] |
		serial_status[SSF_PARITY_BIT];

	// ==========================================================
	// Receive verdict.
	wire logic framing_err;
	wire logic parity_err;
	ssf_rx_check u_check (
		.data(rx_shifter),
		.parity_bit(rx_parity_in),
		.first_stop_bit(rx_stop_in),
		.sync_mode(sync_mode),
		.parity_enable(serial_control[SSF_CTL_PAR_EN]),
		.odd_parity(serial_control[SSF_CTL_ODD]),
		.framing_err(framing_err),
		.parity_err(parity_err)
	);
	// A character is taken only while receiving is enabled and no error flag stands.
	wire logic rx_take = rx_done & rx_en & ~err_any;
	// Full buffer means overrun and the new byte is dropped.
	wire logic set_overrun = rx_take & serial_status[SSF_RX_FULL_BIT];
	wire logic rx_store = rx_take & ~serial_status[SSF_RX_FULL_BIT];
	wire logic set_framing = rx_store & framing_err;
	wire logic set_parity = rx_store & parity_err;
	wire logic set_rx_full = rx_store & ~framing_err & ~parity_err;

	// ==========================================================
	// Read-as-one records for the five clearable flags.
	logic [4:0] armed; // Bits 4..0 follow status bits 7..3.
	wire logic [4:0] flags5 = serial_status[7:3];
	// Zero write clears a flag only when its record is present.
	wire logic [4:0] sw_clear = wr_status ? (armed & ~pwdata[7:3]) : 5'h00;
	wire logic clr_tx_empty = sw_clear[4] | dma_tx_write;
	wire logic clr_rx_full = sw_clear[3] | dma_rx_read;

	// ==========================================================
	// Next values of each flag; a set wins over a clear in the same cycle.
	wire logic next_tx_empty = ~tx_en | tx_load | (serial_status[SSF_TX_EMPTY_BIT] & ~clr_tx_empty);
	wire logic set_tx_end = ~tx_en | (tx_last_bit & serial_status[SSF_TX_EMPTY_BIT]);
	wire logic next_tx_end = set_tx_end | (serial_status[SSF_TX_END_BIT] & ~clr_tx_empty);
	wire logic next_rx_full = set_rx_full | (serial_status[SSF_RX_FULL_BIT] & ~clr_rx_full);
	// Clearing receive enable touches none of the error flags.
	wire logic next_overrun = set_overrun | (serial_status[SSF_OVERRUN_BIT] & ~sw_clear[2]);
	wire logic next_framing = set_framing | (serial_status[SSF_FRAMING_BIT] & ~sw_clear[1]);
	wire logic next_parity = set_parity | (serial_status[SSF_PARITY_BIT] & ~sw_clear[0]);
	// The multiprocessor bit ignores bus writes and follows characters stored in asynchronous multiprocessor format.
	wire logic next_mp = (rx_store & ~sync_mode & mp_fmt) ? rx_mp_in : serial_status[SSF_MP_BIT];
	// Writing ones to the clearable flags never reaches this vector.
	wire logic [7:0] next_status = {next_tx_empty, next_rx_full, next_overrun, next_framing,
		next_parity, next_tx_end, next_mp, 1'b0};

	// ==========================================================
	// Status register; standby forces the reset image.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serial_status <= SSF_STATUS_RESET;
		end
		else if (standby)
		begin
			serial_status <= SSF_STATUS_RESET;
		end
		else
		begin
			serial_status <= next_status;
		end
	end

	// Records arm on a completed read that showed one and drop once the flag is zero.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			armed <= 5'h00;
		end
		else if (standby)
		begin
			armed <= 5'h00;
		end
		else
		begin
			armed <= (armed | (rd_status ? prdata[7:3] : 5'h00)) & next_status[7:3] & flags5;
		end
	end

	// ==========================================================
	// Receive buffer holds while an error flag stands, on overrun and on receive disable.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_buffer <= 8'h00;
		end
		else if (rx_store)
		begin
			rx_buffer <= rx_shifter;
		end
	end

	// Transmit buffer is loaded by the CPU or by the DMA controller.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_buffer <= SSF_TXBUF_RESET;
		end
		else if (dma_tx_write)
		begin
			tx_buffer <= dma_tx_data;
		end
		else if (wr_done & hit_txbuf)
		begin
			tx_buffer <= pwdata[7:0];
		end
	end

	// Control register written by software.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serial_control <= SSF_CONTROL_RESET;
		end
		else if (wr_done & hit_control)
		begin
			serial_control <= pwdata[6:0];
		end
	end

	// Hold-off levels for the engines, registered from the error flags.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_halt <= 1'b0;
			tx_halt <= 1'b0;
		end
		else if (standby)
		begin
			// Standby clears every error flag, so no hold-off may outlive it.
			rx_halt <= 1'b0;
			tx_halt <= 1'b0;
		end
		else
		begin
			rx_halt <= next_overrun | next_framing | next_parity;
			tx_halt <= serial_control[SSF_CTL_SYNC] & (next_overrun | next_framing | next_parity);
		end
	end

	// ==========================================================
	// APB answer: one wait cycle, then pready with data and error.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (access & ~pready)
		begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h00000000 : read_word;
			pslverr <= ~mapped;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ==========================================================
	// Checks.
	a_reset_image: assert property (@(posedge pclk) disable iff (!presetn)
		standby |=> serial_status == SSF_STATUS_RESET)
		else $error("status not at reset image after standby");
	a_no_set_one: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_status && pwdata[SSF_RX_FULL_BIT] && !serial_status[SSF_RX_FULL_BIT] && !set_rx_full && !standby)
		|=> !serial_status[SSF_RX_FULL_BIT])
		else $error("receive-full set by a write");
	a_unarmed_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_status && !armed[1] && serial_status[SSF_FRAMING_BIT] && !standby)
		|=> serial_status[SSF_FRAMING_BIT])
		else $error("framing flag cleared without prior read");
	a_armed_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_status && armed[2] && !pwdata[SSF_OVERRUN_BIT] && !set_overrun)
		|=> !serial_status[SSF_OVERRUN_BIT])
		else $error("armed overrun flag not cleared");
	a_tx_disabled: assert property (@(posedge pclk) disable iff (!presetn)
		!tx_en |=> serial_status[SSF_TX_EMPTY_BIT] && serial_status[SSF_TX_END_BIT])
		else $error("transmit flags not held while disabled");
	a_dma_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(dma_tx_write && tx_en && !tx_load && !tx_last_bit && !standby)
		|=> !serial_status[SSF_TX_EMPTY_BIT] && !serial_status[SSF_TX_END_BIT])
		else $error("DMA write did not clear transmit flags");
	a_overrun_keep: assert property (@(posedge pclk) disable iff (!presetn)
		set_overrun |=> serial_status[SSF_OVERRUN_BIT] && rx_buffer == $past(rx_buffer))
		else $error("overrun lost flag or buffer");
	a_error_stops: assert property (@(posedge pclk) disable iff (!presetn)
		(err_any && !standby) |=> $stable(rx_buffer) && (rx_halt || !err_any))
		else $error("reception continued during error");
	a_framing_store: assert property (@(posedge pclk) disable iff (!presetn)
		(set_framing && !serial_status[SSF_RX_FULL_BIT] && !standby)
		|=> serial_status[SSF_FRAMING_BIT] && !serial_status[SSF_RX_FULL_BIT] && rx_buffer == $past(rx_shifter))
		else $error("framing error handling wrong");
	a_clean_full: assert property (@(posedge pclk) disable iff (!presetn)
		(set_rx_full && !standby) |=> serial_status[SSF_RX_FULL_BIT] ##1 serial_status[SSF_RX_FULL_BIT] || $past(clr_rx_full))
		else $error("clean character did not set receive-full");
	a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !pready) |=> pready ##1 !pready)
		else $error("bus answer timing wrong");
	c_overrun: cover property (@(posedge pclk) disable iff (!presetn) set_overrun);
	c_sw_clear: cover property (@(posedge pclk) disable iff (!presetn) rd_status ##[1:8] (wr_status && sw_clear != 5'h00));
	c_parity: cover property (@(posedge pclk) disable iff (!presetn) set_parity);
	c_tx_end: cover property (@(posedge pclk) disable iff (!presetn) tx_en && tx_last_bit && serial_status[SSF_TX_EMPTY_BIT]);
endmodule
`default_nettype wire

// ### ssf_rx_eng.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Receive engine stand-in: presents one finished character per request.
module ssf_rx_eng
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Request from the bench: {mp, stop, parity, data}.
	input wire logic go,
	input wire logic [10:0] chr,
	// Towards the status block.
	output logic rx_done,
	output logic [7:0] rx_shifter,
	output logic rx_parity_in,
	output logic rx_stop_in,
	output logic rx_mp_in
);
	// One-cycle completion pulse; between characters the fields toggle so stale data never looks valid.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_done <= 1'b0;
			{rx_mp_in, rx_stop_in, rx_parity_in, rx_shifter} <= 11'h000;
		end
		else
		begin
			rx_done <= go;
			{rx_mp_in, rx_stop_in, rx_parity_in, rx_shifter} <= go ? chr : ~{rx_mp_in, rx_stop_in, rx_parity_in, rx_shifter};
		end
	end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench: a reference model of the flags is compared at every result.
module tb_top import ssf_pkg::*;;
	// Bus, event and engine stimulus.
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, standby = 0, go = 0, er;
	logic [7:0] paddr = 0, dma_tx_data = 0, d;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0] ev = 4'h0;
	logic [10:0] chr = 0;
	logic pready, pslverr, rx_done, rx_parity_in, rx_stop_in, rx_mp_in, rx_halt, tx_halt;
	logic [7:0] rx_shifter, tx_buffer, rx_buffer, serial_status;
	logic [6:0] serial_control;
	// Reference model: status, read records, receive buffer, control.
	logic [7:0] m_st = 8'h84, m_arm = 0, m_rb = 0;
	logic [6:0] m_ctl = 0;
	int fail_count = 0, cmp_count = 0, cyc = 0, seed = 32'h03833B02;
	ssf_status DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.standby(standby), .tx_load(ev[0]), .tx_last_bit(ev[1]), .rx_done(rx_done),
		.rx_shifter(rx_shifter), .rx_parity_in(rx_parity_in), .rx_stop_in(rx_stop_in), .rx_mp_in(rx_mp_in),
		.dma_tx_write(ev[2]), .dma_tx_data(dma_tx_data), .dma_rx_read(ev[3]), .tx_buffer(tx_buffer),
		.rx_buffer(rx_buffer), .serial_status(serial_status), .serial_control(serial_control),
		.rx_halt(rx_halt), .tx_halt(tx_halt));
	ssf_rx_eng ENG (.pclk(pclk), .presetn(presetn), .go(go), .chr(chr), .rx_done(rx_done),
		.rx_shifter(rx_shifter), .rx_parity_in(rx_parity_in), .rx_stop_in(rx_stop_in), .rx_mp_in(rx_mp_in));
	// A 100 ns clock.
	always #50 pclk = ~pclk;
	// ==========================================================
	// Checking and closing.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		$display("Compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			results();
		end
	end
	// ==========================================================
	// APB master: setup, then access held until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// Model upkeep: transmit flags held while disabled, records drop with their flag.
	task automatic fix();
		if (!m_ctl[SSF_CTL_TX_EN])
			m_st = m_st | 8'h84;
		m_arm = m_arm & m_st;
	endtask
	// Status read arms the record of every flag seen at one.
	task automatic rd_st();
		apb(1'b0, SSF_STATUS_OFS, 32'h0);
		chk("status", rd, {24'h0, m_st});
		chk("status_port", 32'(serial_status), 32'(m_st));
		m_arm = m_arm | m_st;
	endtask
	// Status write: only armed zero bits clear; transmit-end follows transmit-empty.
	task automatic wr_st(input logic [7:0] v);
		apb(1'b1, SSF_STATUS_OFS, {24'h0, v});
		m_st[7:3] = m_st[7:3] & ~(m_arm[7:3] & ~v[7:3]);
		m_st[2] = m_st[2] & m_st[7];
		fix();
	endtask
	task automatic wr_ctl(input logic [6:0] v);
		apb(1'b1, SSF_CONTROL_OFS, {25'h0, v});
		@(posedge pclk);
		m_ctl = v;
		fix();
		chk("control", 32'(serial_control), 32'(m_ctl));
	endtask
	// Event pulse: 0 load, 1 last bit, 2 DMA write, 3 DMA read.
	task automatic evt(input int k);
		d = 8'($random(seed));
		@(posedge pclk);
		{ev, dma_tx_data} <= {4'(1 << k), d};
		@(posedge pclk);
		ev <= 4'h0;
		@(posedge pclk);
		if (k == 0)
			m_st[7] = 1'b1;
		if (k == 1)
			m_st[2] = m_st[2] | m_st[7];
		if (k == 2)
			m_st = m_st & 8'h7B;
		if (k == 3)
			m_st[6] = 1'b0;
		fix();
		if (k == 2)
			chk("tx_buffer", 32'(tx_buffer), 32'(d));
	endtask
	// One received character through the engine stand-in.
	task automatic rx(input logic [7:0] dv, input logic p, input logic s, input logic mp);
		logic fe, pe;
		@(posedge pclk);
		{go, chr} <= {1'b1, mp, s, p, dv};
		@(posedge pclk);
		go <= 1'b0;
		repeat (2) @(posedge pclk);
		fe = !m_ctl[SSF_CTL_SYNC] && !s;
		pe = !m_ctl[SSF_CTL_SYNC] && m_ctl[SSF_CTL_PAR_EN] && ((^{dv, p}) != m_ctl[SSF_CTL_ODD]);
		if (m_ctl[SSF_CTL_RX_EN] && m_st[5:3] == 3'b000)
		begin
			if (m_st[6])
				m_st[5] = 1'b1;
			else
			begin
				m_rb = dv;
				m_st[6:3] = {!(fe || pe), 1'b0, fe, pe};
				if (m_ctl[SSF_CTL_MP_FMT])
					m_st[1] = mp;
			end
		end
		chk("rx_buffer", 32'(rx_buffer), 32'(m_rb));
		chk("rx_halt", 32'(rx_halt), 32'(|m_st[5:3]));
		chk("tx_halt", 32'(tx_halt), 32'(|m_st[5:3] & m_ctl[SSF_CTL_SYNC]));
		fix();
	endtask
	// ==========================================================
	// Main sequence.
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd_st();
		wr_st(8'hFF);
		rd_st();
		wr_ctl(7'h03);
		evt(2);
		rd_st();
		evt(0);
		wr_st(8'h00);
		rd_st();
		wr_st(8'h00);
		rd_st();
		evt(0);
		evt(1);
		rd_st();
		evt(2);
		wr_ctl(7'h02);
		evt(2);
		rd_st();
		wr_ctl(7'h03);
		rx(8'($random(seed)), 1'b0, 1'b1, 1'b0);
		rd_st();
		rx(8'($random(seed)), 1'b0, 1'b1, 1'b0);
		rx(8'($random(seed)), 1'b0, 1'b1, 1'b0);
		rd_st();
		wr_st(8'hDF);
		rd_st();
		evt(3);
		rd_st();
		wr_ctl(7'h23);
		rx(8'($random(seed)), 1'b0, 1'b0, 1'b0);
		rd_st();
		wr_ctl(7'h21);
		rd_st();
		wr_ctl(7'h27);
		rx(8'($random(seed)), 1'b0, 1'b1, 1'b0);
		wr_st(8'h00);
		for (int i = 0; i < 4; i++)
		begin
			d = 8'($random(seed));
			wr_ctl(7'h0B | {2'b00, i[0], 4'h0});
			rx(d, ^d ^ i[0] ^ i[1], 1'b1, 1'b0);
			rd_st();
			wr_st(8'h00);
		end
		wr_ctl(7'h43);
		rx(8'($random(seed)), 1'b0, 1'b1, 1'b1);
		rd_st();
		apb(1'b0, 8'h10, 32'h0);
		chk("slverr", 32'(er), 32'h1);
		chk("unmapped", rd, 32'h0);
		standby <= 1'b1;
		repeat (2) @(posedge pclk);
		standby <= 1'b0;
		m_st = 8'h84;
		m_arm = 8'h00;
		rd_st();
		results();
	end
endmodule
`default_nettype wire
